/* File: core/slpc_bank.sv */
// APB register bank for lane four to seven de-emphasis and link PLL control.
// Assumes an APB master on pclk and a loss-of-lock level from another domain.
//
// Function
// - Three-bit posttap level per lane, bits six-four.
// - Posttap enable in bit seven, reserved low nibble.
// - Calibration reset register resets to zero.
// - Value 0x04 holds PLL calibration in reset.
// - Start-up control resets to 0x0f, normal.
// - Value 0x4f holds PLL start-up circuit reset.
// - Value 0x80 clears the latched unlock flag.
// - Unlock control resets zero, flag latches failures.
`timescale 1ns/1ps
`include "slpc_defines.svh"

module slpc_bank
    import slpc_pkg::*;
#(
    parameter int LANES = 4
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [15:0]        paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Lane driver controls, entry zero is lane four
    output logic      [LANES-1:0]   posttap_en,
    output slpc_level_t             posttap_level [LANES],
    // Link PLL controls and status
    output logic                    pll_cal_reset,
    output logic                    pll_startup_reset,
    input  wire logic               pll_lock_lost,
    output logic                    pll_unlock_flag,
    // Interrupt
    output logic                    irq
);

    // ======================================================================
    // Bus decode.
    logic [13:0] idx;
    logic        setup_acc;
    logic        wr_en;
    logic        rd_hit;
    logic        wr_ok;
    logic [7:0]  rd_mux;
    logic [7:0]  wbyte;

    slpc_byte_t  lane_q [LANES];
    slpc_byte_t  cal_q;
    slpc_byte_t  startup_q;
    slpc_byte_t  unlock_q;
    logic [1:0]  status_q;
    logic [1:0]  enable_q;
    logic        pready_q;
    logic        err_q;
    logic [31:0] prdata_q;
    logic        lost_meta_q;
    logic        lost_sync_q;
    logic        lost_prev_q;
    logic        flag_q;

    assign idx       = paddr[15:2];
    assign wbyte     = pwdata[7:0];
    assign setup_acc = psel && penable && !pready_q;
    assign wr_en     = psel && penable && pready_q && pwrite && !err_q
                       && pstrb[0];

    // Lane registers occupy consecutive indices from lane four upward.
    function automatic logic lane_hit(input logic [13:0] a, input int n);
        lane_hit = (a == `SLPC_LANE4_IDX + 14'(n));
    endfunction : lane_hit

    always_comb begin
        rd_hit = 1'b1;
        wr_ok  = 1'b1;
        rd_mux = 8'h00;
        for (int i = 0; i < LANES; i++) begin
            if (lane_hit(idx, i)) begin
                rd_mux = lane_q[i];
            end
        end
        if (paddr[1:0] != 2'h0) begin
            rd_hit = 1'b0;
            wr_ok  = 1'b0;
        end else if (idx >= `SLPC_LANE4_IDX
                     && idx < `SLPC_LANE4_IDX + 14'(LANES)) begin
            rd_hit = 1'b1;
        end else begin
            unique case (idx)
                `SLPC_PLL_CAL_IDX:     rd_mux = cal_q;
                `SLPC_PLL_STARTUP_IDX: rd_mux = startup_q;
                `SLPC_PLL_UNLOCK_IDX:  rd_mux = unlock_q;
                `SLPC_IRQ_STATUS_IDX: begin
                    rd_mux = {6'h00, status_q};
                    wr_ok  = 1'b0;
                end
                `SLPC_IRQ_ENABLE_IDX:  rd_mux = {6'h00, enable_q};
                `SLPC_IRQ_CLEAR_IDX:   rd_mux = 8'h00;
                `SLPC_LINK_STATE_IDX: begin
                    rd_mux = {6'h00, lost_sync_q, flag_q};
                    wr_ok  = 1'b0;
                end
                default: begin
                    rd_hit = 1'b0;
                    wr_ok  = 1'b0;
                end
            endcase
        end
    end

    // ======================================================================
    // One wait state: data and error are captured on the same edge that raises pready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            err_q    <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_acc;
            if (setup_acc) begin
                err_q    <= pwrite ? !wr_ok : !rd_hit;
                prdata_q <= (!pwrite && rd_hit) ? {24'h00_0000, rd_mux}
                                                : 32'h0000_0000;
            end
        end
    end

    assign pready  = pready_q;
    assign pslverr = pready_q && err_q;
    assign prdata  = prdata_q;

    // ======================================================================
    // Lane de-emphasis registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < LANES; i++) begin
                lane_q[i] <= `SLPC_LANE_RST;
            end
        end else begin
            for (int i = 0; i < LANES; i++) begin
                if (wr_en && lane_hit(idx, i)) begin
                    lane_q[i] <= wbyte;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            posttap_en[i]    = lane_q[i][`SLPC_POSTTAP_EN_BIT];
            posttap_level[i] = slpc_level_t'(
                lane_q[i][`SLPC_LEVEL_MSB:`SLPC_LEVEL_LSB]);
        end
    end

    // ======================================================================
    // Link PLL command registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_q     <= `SLPC_PLL_CAL_RST;
            startup_q <= `SLPC_PLL_STARTUP_RST;
            unlock_q  <= `SLPC_PLL_UNLOCK_RST;
        end else if (wr_en) begin
            if (idx == `SLPC_PLL_CAL_IDX) begin
                cal_q <= wbyte;
            end
            if (idx == `SLPC_PLL_STARTUP_IDX) begin
                startup_q <= wbyte;
            end
            if (idx == `SLPC_PLL_UNLOCK_IDX) begin
                unlock_q <= wbyte;
            end
        end
    end

    // Undocumented command values leave the PLL in normal operation.
    assign pll_cal_reset     = (cal_q == `SLPC_CAL_RESET_CMD);
    assign pll_startup_reset = (startup_q == `SLPC_STARTUP_RST_CMD);

    // ======================================================================
    // Loss-of-lock synchroniser and latched flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_meta_q <= 1'b0;
            lost_sync_q <= 1'b0;
            lost_prev_q <= 1'b0;
        end else begin
            lost_meta_q <= pll_lock_lost;
            lost_sync_q <= lost_meta_q;
            lost_prev_q <= lost_sync_q;
        end
    end

    // A failure present while the clear command is held still latches.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (lost_sync_q) begin
            flag_q <= 1'b1;
        end else if (unlock_q == `SLPC_UNLOCK_CLR_CMD) begin
            flag_q <= 1'b0;
        end
    end

    assign pll_unlock_flag = flag_q;

    // ======================================================================
    // Interrupt status, enable and write-one-to-clear.
    logic [1:0] ev;
    logic [1:0] clr;

    assign ev[`SLPC_IRQ_LOST_BIT]   = lost_sync_q && !lost_prev_q;
    assign ev[`SLPC_IRQ_REGAIN_BIT] = !lost_sync_q && lost_prev_q;
    assign clr = (wr_en && idx == `SLPC_IRQ_CLEAR_IDX) ? wbyte[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `SLPC_IRQ_RST;
        end else begin
            status_q <= (status_q & ~clr) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= `SLPC_IRQ_RST;
        end else if (wr_en && idx == `SLPC_IRQ_ENABLE_IDX) begin
            enable_q <= wbyte[1:0];
        end
    end

    assign irq = |(status_q & enable_q);

    // ======================================================================
    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_level_write;
        wr_en && idx == `SLPC_LANE4_IDX
        |=> posttap_level[0] == $past(pwdata[6:4]);
    endproperty
    a_level_write: assert property (p_level_write)
        else $error("lane posttap level did not follow the write");

    property p_enable_write;
        wr_en && idx == `SLPC_LANE4_IDX + 14'h3
        |=> posttap_en[3] == $past(pwdata[7])
        ##1 posttap_en[3] == $past(pwdata[7], 2);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("lane posttap enable did not follow the write");

    property p_cal_idle;
        cal_q == 8'h00 |-> !pll_cal_reset;
    endproperty
    a_cal_idle: assert property (p_cal_idle)
        else $error("calibration reset active with zero register");

    property p_cal_cmd;
        wr_en && idx == `SLPC_PLL_CAL_IDX && wbyte == 8'h04
        |=> pll_cal_reset until (wr_en && idx == `SLPC_PLL_CAL_IDX);
    endproperty
    a_cal_cmd: assert property (p_cal_cmd)
        else $error("calibration reset not held after command");

    property p_startup_idle;
        startup_q == 8'h0f |-> !pll_startup_reset;
    endproperty
    a_startup_idle: assert property (p_startup_idle)
        else $error("start-up reset active with normal value");

    property p_startup_cmd;
        wr_en && idx == `SLPC_PLL_STARTUP_IDX && wbyte == 8'h4f
        |=> pll_startup_reset;
    endproperty
    a_startup_cmd: assert property (p_startup_cmd)
        else $error("start-up reset not applied after command");

    property p_unlock_clear;
        unlock_q == 8'h80 && !lost_sync_q |=> !pll_unlock_flag;
    endproperty
    a_unlock_clear: assert property (p_unlock_clear)
        else $error("unlock flag not cleared by command");

    property p_unlock_latch;
        $rose(lost_sync_q) |=> pll_unlock_flag ##1 (pll_unlock_flag
            || $past(unlock_q) == 8'h80);
    endproperty
    a_unlock_latch: assert property (p_unlock_latch)
        else $error("unlock flag did not latch a failure");

    property p_readback;
        setup_acc && !pwrite && idx == `SLPC_PLL_STARTUP_IDX
        && paddr[1:0] == 2'h0
        |=> pready && prdata[7:0] == $past(startup_q) && !pslverr;
    endproperty
    a_readback: assert property (p_readback)
        else $error("start-up register read back wrong value");

    property p_sticky;
        status_q[0] && !clr[0] |=> status_q[0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("interrupt status bit lost without clear");

    c_lane_write: cover property (wr_en && lane_hit(idx, 2));
    c_cal_reset:  cover property ($rose(pll_cal_reset));
    c_flag_clear: cover property ($fell(pll_unlock_flag));
    c_irq:        cover property ($rose(irq));

endmodule : slpc_bank

/* File: pkg/slpc_defines.svh */
// Constants for the serial lane emphasis and link PLL control bank.
// Assumes inclusion by bare name from the package and the core module.
`ifndef SLPC_DEFINES_SVH
`define SLPC_DEFINES_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define SLPC_LANE4_IDX        14'h05c8
`define SLPC_LANE5_IDX        14'h05c9
`define SLPC_LANE6_IDX        14'h05ca
`define SLPC_LANE7_IDX        14'h05cb
`define SLPC_PLL_CAL_IDX      14'h1222
`define SLPC_PLL_STARTUP_IDX  14'h1228
`define SLPC_PLL_UNLOCK_IDX   14'h1262
`define SLPC_IRQ_STATUS_IDX   14'h1300
`define SLPC_IRQ_ENABLE_IDX   14'h1301
`define SLPC_IRQ_CLEAR_IDX    14'h1302
`define SLPC_LINK_STATE_IDX   14'h1303

// ==========================================================================
// Field positions.
`define SLPC_POSTTAP_EN_BIT   7
`define SLPC_LEVEL_MSB        6
`define SLPC_LEVEL_LSB        4
`define SLPC_IRQ_LOST_BIT     0
`define SLPC_IRQ_REGAIN_BIT   1

// ==========================================================================
// Reset values and command codes.
`define SLPC_LANE_RST         8'h00
`define SLPC_PLL_CAL_RST      8'h00
`define SLPC_PLL_STARTUP_RST  8'h0f
`define SLPC_PLL_UNLOCK_RST   8'h00
`define SLPC_IRQ_RST          2'h0
`define SLPC_CAL_RESET_CMD    8'h04
`define SLPC_STARTUP_RST_CMD  8'h4f
`define SLPC_UNLOCK_CLR_CMD   8'h80

`endif

/* File: pkg/slpc_pkg.sv */
// Types shared by the lane emphasis and link PLL control bank.
// Assumes the constants header is on the include path.
`include "slpc_defines.svh"

package slpc_pkg;

    // ======================================================================
    // Posttap de-emphasis levels.
    typedef enum logic [2:0] {
        SLPC_LVL_0DB  = 3'h0,
        SLPC_LVL_3DB  = 3'h1,
        SLPC_LVL_6DB  = 3'h2,
        SLPC_LVL_9DB  = 3'h3,
        SLPC_LVL_12DB = 3'h4
    } slpc_level_t;

    typedef logic [7:0] slpc_byte_t;

endpackage : slpc_pkg

/* File: verif/tb.sv */
// Self-checking bench for the lane emphasis and link PLL control bank.
// Assumes the package, the constants header and the core are compiled first.
`timescale 1ns/1ps
`include "slpc_defines.svh"

module tb
    import slpc_pkg::*;
;
    // ======================================================================
    // Signals
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [15:0]       paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [3:0]        posttap_en;
    slpc_level_t       lvl [4];
    logic              pll_cal_reset;
    logic              pll_startup_reset;
    logic              pll_lock_lost;
    logic              pll_unlock_flag;
    logic              irq;
    int                miscompares;
    int                samples_checked;
    logic [31:0]       lfsr_q;
    logic [7:0]        mdl [int];
    logic [31:0]       rd;
    logic              er;

    slpc_bank i_slpc_bank (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .posttap_en(posttap_en), .posttap_level(lvl),
        .pll_cal_reset(pll_cal_reset), .pll_startup_reset(pll_startup_reset),
        .pll_lock_lost(pll_lock_lost), .pll_unlock_flag(pll_unlock_flag),
        .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ======================================================================
    // Helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen high.
    // Values read just after an edge are those that the edge sampled.
    task automatic apb(logic w, logic [13:0] ix, logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {ix, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wreg(logic [13:0] ix, logic [7:0] d);
        apb(1'b1, ix, d);
        if (mdl.exists(int'(ix)))
            mdl[int'(ix)] = d;
        @(negedge pclk);
    endtask : wreg

    task automatic rx(logic [13:0] ix, logic [7:0] e, logic ee);
        apb(1'b0, ix, 8'h00);
        chk("prdata", {24'h0, e}, rd);
        chk("pslverr", {31'h0, ee}, {31'h0, er});
    endtask : rx

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // ======================================================================
    // Main sequence
    initial begin
        miscompares = 0;
        samples_checked = 0;
        lfsr_q = 32'ha84292fe;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        pll_lock_lost = 1'b0;
        for (int i = 0; i < 4; i++)
            mdl[`SLPC_LANE4_IDX + i] = `SLPC_LANE_RST;
        mdl[`SLPC_PLL_CAL_IDX] = `SLPC_PLL_CAL_RST;
        mdl[`SLPC_PLL_STARTUP_IDX] = `SLPC_PLL_STARTUP_RST;
        mdl[`SLPC_PLL_UNLOCK_IDX] = `SLPC_PLL_UNLOCK_RST;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("posttap_en", 32'h0, {28'h0, posttap_en});
        chk("cal_reset", 32'h0, {31'h0, pll_cal_reset});
        chk("startup_reset", 32'h0, {31'h0, pll_startup_reset});
        chk("unlock_flag", 32'h0, {31'h0, pll_unlock_flag});
        foreach (mdl[i]) rx(14'(i), mdl[i], 1'b0);
        for (int l = 0; l < 4; l++) begin
            for (int c = 0; c < 5; c++) begin
                lfsr_q = lfsr(lfsr_q);
                wreg(14'(`SLPC_LANE4_IDX + l), {lfsr_q[7], 3'(c), lfsr_q[3:0]});
                chk("en", {31'h0, lfsr_q[7]}, {31'h0, posttap_en[l]});
                chk("level", 32'(c), {29'h0, lvl[l]});
                rx(14'(`SLPC_LANE4_IDX + l), mdl[`SLPC_LANE4_IDX + l], 1'b0);
            end
        end
        wreg(`SLPC_PLL_CAL_IDX, `SLPC_CAL_RESET_CMD);
        chk("cal_reset", 32'h1, {31'h0, pll_cal_reset});
        rx(`SLPC_PLL_CAL_IDX, 8'h04, 1'b0);
        wreg(`SLPC_PLL_CAL_IDX, 8'h00);
        chk("cal_reset", 32'h0, {31'h0, pll_cal_reset});
        wreg(`SLPC_PLL_STARTUP_IDX, `SLPC_STARTUP_RST_CMD);
        chk("startup_reset", 32'h1, {31'h0, pll_startup_reset});
        wreg(`SLPC_PLL_STARTUP_IDX, 8'h0f);
        chk("startup_reset", 32'h0, {31'h0, pll_startup_reset});
        @(posedge pclk) pll_lock_lost <= 1'b1;
        repeat (6) @(negedge pclk);
        chk("unlock_flag", 32'h1, {31'h0, pll_unlock_flag});
        rx(`SLPC_LINK_STATE_IDX, 8'h03, 1'b0);
        @(posedge pclk) pll_lock_lost <= 1'b0;
        repeat (6) @(negedge pclk);
        chk("unlock_flag", 32'h1, {31'h0, pll_unlock_flag});
        rx(`SLPC_LINK_STATE_IDX, 8'h01, 1'b0);
        rx(`SLPC_IRQ_STATUS_IDX, 8'h03, 1'b0);
        chk("irq", 32'h0, {31'h0, irq});
        wreg(`SLPC_IRQ_ENABLE_IDX, 8'h01);
        chk("irq", 32'h1, {31'h0, irq});
        wreg(`SLPC_IRQ_ENABLE_IDX, 8'h00);
        chk("irq", 32'h0, {31'h0, irq});
        wreg(`SLPC_IRQ_CLEAR_IDX, 8'h03);
        wreg(`SLPC_IRQ_ENABLE_IDX, 8'h03);
        chk("irq", 32'h0, {31'h0, irq});
        rx(`SLPC_IRQ_STATUS_IDX, 8'h00, 1'b0);
        wreg(`SLPC_PLL_UNLOCK_IDX, `SLPC_UNLOCK_CLR_CMD);
        @(negedge pclk);
        chk("unlock_flag", 32'h0, {31'h0, pll_unlock_flag});
        wreg(`SLPC_PLL_UNLOCK_IDX, 8'h00);
        rx(`SLPC_PLL_UNLOCK_IDX, 8'h00, 1'b0);
        rx(14'h0100, 8'h00, 1'b1);
        apb(1'b1, `SLPC_IRQ_STATUS_IDX, 8'hff);
        chk("ro_write_err", 32'h1, {31'h0, er});
        @(posedge pclk) pstrb <= 4'he;
        apb(1'b1, `SLPC_LANE4_IDX, 8'hff);
        @(posedge pclk) pstrb <= 4'hf;
        chk("strobe_err", 32'h0, {31'h0, er});
        foreach (mdl[i]) rx(14'(i), mdl[i], 1'b0);
        conclude();
    end
endmodule : tb
